// *** logic/tec_regs.vh ***
// Register offsets, field positions, reset values and timing counts
`ifndef TEC_REGS_VH
`define TEC_REGS_VH

// Register byte offsets
`define TEC_OFS_CTRL 8'h00
`define TEC_OFS_CMP_LO 8'h04
`define TEC_OFS_CMP_HI 8'h08
`define TEC_OFS_CAPTURE 8'h0C
`define TEC_OFS_COUNT 8'h10
`define TEC_OFS_IRQ_STAT 8'h14
`define TEC_OFS_IRQ_MASK 8'h18
`define TEC_OFS_RUN_STAT 8'h1C

// Control register fields
`define TEC_CTRL_START_LSB 0
`define TEC_CTRL_START_MSB 1
`define TEC_CTRL_CLKSEL_LSB 2
`define TEC_CTRL_CLKSEL_MSB 3
`define TEC_CTRL_STOPSEL 4
`define TEC_CTRL_ACAP 5
`define TEC_CTRL_EXTMODE 6
`define TEC_CTRL_TAP 7

// Start control codes
`define TEC_START_STOP 2'h0
`define TEC_START_CMD 2'h1
`define TEC_START_RISE 2'h2
`define TEC_START_FALL 2'h3

// Source clock select codes
`define TEC_CLK_DIV11 2'h0
`define TEC_CLK_DIV7 2'h1
`define TEC_CLK_DIV3 2'h2

// Interrupt status bit
`define TEC_IRQ_MATCH 0

// Reset values
`define TEC_RST_CMP 16'hFFFF
`define TEC_RST_CMP_LO 8'hFF
`define TEC_RST_CTRL 8'h00

// Filter times in fast oscillator periods, clocks in MHz
`define TEC_FC_MHZ 200
`define TEC_SYS_MHZ 200
`define TEC_FILT_REJECT_FC 4
`define TEC_FILT_DETECT_FC 12
`define TEC_FILT_REJECT_CYC (`TEC_FILT_REJECT_FC * `TEC_SYS_MHZ / `TEC_FC_MHZ)
`define TEC_FILT_DETECT_CYC (`TEC_FILT_DETECT_FC * `TEC_SYS_MHZ / `TEC_FC_MHZ)
`define TEC_FILT_ACCEPT_CYC ((`TEC_FILT_REJECT_CYC + `TEC_FILT_DETECT_CYC) / 2)

`endif

// *** logic/tec_pin_filter.v ***
// Synchroniser, noise filter and edge detector for the counter input pin
`timescale 1ns/1ps
`default_nettype none
`include "tec_regs.vh"

module tec_pin_filter
(
   // Clock and reset
   input wire sys_clk,
   input wire rst,
   // Pin and mode
   input wire pin_in,
   input wire bypass,
   // Filtered edges
   output wire rise,
   output wire fall
);

   localparam [31:0] ACCEPT_CYC = `TEC_FILT_ACCEPT_CYC;
   localparam [3:0] ACCEPT = ACCEPT_CYC[3:0];

   reg sync1_ff;
   reg sync2_ff;
   reg level_ff;
   reg prev_ff;
   reg [3:0] cnt_ff;

   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
      end
      else
      begin
         sync1_ff <= pin_in;
         sync2_ff <= sync1_ff;
      end
   end

   // Unless bypass is set, a level must hold ACCEPT cycles before it is taken
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         level_ff <= 1'b0;
         prev_ff <= 1'b0;
         cnt_ff <= 4'h0;
      end
      else
      begin
         prev_ff <= level_ff;
         if (sync2_ff == level_ff)
            cnt_ff <= 4'h0;
         else if (bypass || cnt_ff == ACCEPT - 4'h1)
         begin
            level_ff <= sync2_ff;
            cnt_ff <= 4'h0;
         end
         else
            cnt_ff <= cnt_ff + 4'h1;
      end
   end

   assign rise = level_ff & ~prev_ff;
   assign fall = ~level_ff & prev_ff;

endmodule // tec_pin_filter

`default_nettype wire

// *** logic/tec_timer.v ***
// 16-bit timer with free-running and external-trigger modes
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "tec_regs.vh"

module tec_timer
(
   // Clock and reset
   input wire SYS_CLK,
   input wire RST,
   // Register port
   input wire [7:0] ADDR,
   input wire [15:0] WDATA,
   input wire WR,
   input wire RD,
   output reg [15:0] RDATA,
   // Power mode and slow oscillator
   input wire PWR_LOW_SPEED,
   input wire PWR_STOP_ENTER,
   input wire SLOW_OSC_TICK,
   // Counter input pin
   input wire CNT_IN_PIN,
   // Interrupts
   output wire MATCH_PULSE,
   output wire IRQ
);

   // Control fields
   reg [1:0] start_ff;
   reg [1:0] clksel_ff;
   reg stopsel_ff;
   reg acap_ff;
   reg extmode_ff;
   reg tap_ff;
   reg [1:0] nxt_start;

   // Data registers
   reg [15:0] cnt_ff;
   reg [15:0] cmp_ff;
   reg [7:0] cmp_lo_ff;
   reg [15:0] cmp_pend_ff;
   reg pend_ff;
   reg [15:0] cap_ff;
   reg run_ff;
   reg [15:0] nxt_cnt;
   reg nxt_run;
   reg match_evt;

   // Interrupt registers
   reg stat_ff;
   reg mask_ff;

   // Prescaler
   reg [10:0] div_ff;
   reg [2:0] sdiv_ff;
   reg src_tick;

   // Pin edges
   wire pin_rise;
   wire pin_fall;
   wire trig_edge;
   wire opp_edge;

   // Decodes
   wire wr_ctrl;
   wire wr_cmp_lo;
   wire wr_cmp_hi;
   wire wr_stat;
   wire wr_mask;
   reg [15:0] rd_mux;

   assign wr_ctrl = WR && (ADDR == `TEC_OFS_CTRL);
   assign wr_cmp_lo = WR && (ADDR == `TEC_OFS_CMP_LO);
   assign wr_cmp_hi = WR && (ADDR == `TEC_OFS_CMP_HI);
   assign wr_stat = WR && (ADDR == `TEC_OFS_IRQ_STAT);
   assign wr_mask = WR && (ADDR == `TEC_OFS_IRQ_MASK);

   tec_pin_filter u_filter
   (
      .sys_clk(SYS_CLK),
      .rst(RST),
      .pin_in(CNT_IN_PIN),
      .bypass(PWR_LOW_SPEED),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // Rising start code selects the rising edge as trigger
   assign trig_edge = (start_ff == `TEC_START_RISE) ? pin_rise :
                      (start_ff == `TEC_START_FALL) ? pin_fall : 1'b0;
   assign opp_edge = (start_ff == `TEC_START_RISE) ? pin_fall :
                     (start_ff == `TEC_START_FALL) ? pin_rise : 1'b0;

   // Free-running fast and slow dividers
   always @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         div_ff <= 11'h000;
         sdiv_ff <= 3'h0;
      end
      else
      begin
         div_ff <= div_ff + 11'h001;
         if (SLOW_OSC_TICK)
            sdiv_ff <= sdiv_ff + 3'h1;
      end
   end

   // Source clock tick select
   always @*
   begin
      src_tick = 1'b0;
      if (PWR_LOW_SPEED)
      begin
         if (clksel_ff == `TEC_CLK_DIV11)
            src_tick = SLOW_OSC_TICK && (sdiv_ff == 3'h7);
      end
      else
      begin
         case (clksel_ff)
            `TEC_CLK_DIV11:
               src_tick = tap_ff ? (SLOW_OSC_TICK && (sdiv_ff == 3'h7))
                                 : (div_ff == 11'h7FF);
            `TEC_CLK_DIV7:
               src_tick = (div_ff[6:0] == 7'h7F);
            `TEC_CLK_DIV3:
               src_tick = (div_ff[2:0] == 3'h7);
            default:
               src_tick = 1'b0;
         endcase
      end
   end

   // Start field: stop power mode overrides any write
   always @*
   begin
      nxt_start = start_ff;
      if (wr_ctrl)
         nxt_start = WDATA[`TEC_CTRL_START_MSB:`TEC_CTRL_START_LSB];
      if (PWR_STOP_ENTER)
         nxt_start = `TEC_START_STOP;
   end

   always @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         start_ff <= `TEC_START_STOP;
         clksel_ff <= 2'h0;
         stopsel_ff <= 1'b0;
         acap_ff <= 1'b0;
         extmode_ff <= 1'b0;
         tap_ff <= 1'b0;
      end
      else
      begin
         start_ff <= nxt_start;
         if (wr_ctrl)
         begin
            clksel_ff <= WDATA[`TEC_CTRL_CLKSEL_MSB:`TEC_CTRL_CLKSEL_LSB];
            stopsel_ff <= WDATA[`TEC_CTRL_STOPSEL];
            acap_ff <= WDATA[`TEC_CTRL_ACAP];
            extmode_ff <= WDATA[`TEC_CTRL_EXTMODE];
            tap_ff <= WDATA[`TEC_CTRL_TAP];
         end
      end
   end

   // Counter and run state
   always @*
   begin
      nxt_cnt = cnt_ff;
      nxt_run = run_ff;
      match_evt = 1'b0;
      if (start_ff == `TEC_START_STOP)
      begin
         nxt_cnt = 16'h0000;
         nxt_run = 1'b0;
      end
      else if (!extmode_ff)
      begin
         nxt_run = (start_ff == `TEC_START_CMD);
         if (nxt_run && src_tick)
         begin
            if (cnt_ff == cmp_ff)
            begin
               nxt_cnt = 16'h0000;
               match_evt = 1'b1;
            end
            else
               nxt_cnt = cnt_ff + 16'h0001;
         end
      end
      else if (start_ff != `TEC_START_CMD)
      begin
         if (!run_ff)
         begin
            if (trig_edge)
            begin
               nxt_run = 1'b1;
               nxt_cnt = 16'h0000;
            end
         end
         else if (src_tick && cnt_ff == cmp_ff)
         begin
            nxt_cnt = 16'h0000;
            nxt_run = 1'b0;
            match_evt = 1'b1;
         end
         else if (stopsel_ff && opp_edge)
         begin
            nxt_cnt = 16'h0000;
            nxt_run = 1'b0;
         end
         else if (src_tick)
            nxt_cnt = cnt_ff + 16'h0001;
      end
   end

   always @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         cnt_ff <= 16'h0000;
         run_ff <= 1'b0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
         run_ff <= nxt_run;
      end
   end

   // Auto-capture of the running count
   always @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
         cap_ff <= 16'h0000;
      else if (acap_ff && src_tick)
         cap_ff <= cnt_ff;
   end

   // Compare: lower byte staged, upper byte arms, tick loads
   always @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         cmp_ff <= `TEC_RST_CMP;
         cmp_lo_ff <= `TEC_RST_CMP_LO;
         cmp_pend_ff <= `TEC_RST_CMP;
         pend_ff <= 1'b0;
      end
      else
      begin
         if (wr_cmp_lo)
            cmp_lo_ff <= WDATA[7:0];
         if (wr_cmp_hi)
         begin
            cmp_pend_ff <= {WDATA[7:0], cmp_lo_ff};
            pend_ff <= 1'b1;
         end
         else if (pend_ff && src_tick)
         begin
            cmp_ff <= cmp_pend_ff;
            pend_ff <= 1'b0;
         end
      end
   end

   // Sticky match status, write one to clear, event wins
   always @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         stat_ff <= 1'b0;
         mask_ff <= 1'b0;
      end
      else
      begin
         stat_ff <= (stat_ff & ~(wr_stat & WDATA[`TEC_IRQ_MATCH])) |
                    match_evt;
         if (wr_mask)
            mask_ff <= WDATA[`TEC_IRQ_MATCH];
      end
   end

   assign MATCH_PULSE = match_evt;
   assign IRQ = stat_ff & mask_ff;

   // Read mux; unmapped offsets read zero
   always @*
   begin
      case (ADDR)
         `TEC_OFS_CTRL:
            rd_mux = {8'h00, tap_ff, extmode_ff, acap_ff, stopsel_ff,
                      clksel_ff, start_ff};
         `TEC_OFS_CMP_LO:
            rd_mux = {8'h00, cmp_ff[7:0]};
         `TEC_OFS_CMP_HI:
            rd_mux = {8'h00, cmp_ff[15:8]};
         `TEC_OFS_CAPTURE:
            rd_mux = cap_ff;
         `TEC_OFS_COUNT:
            rd_mux = cnt_ff;
         `TEC_OFS_IRQ_STAT:
            rd_mux = {15'h0000, stat_ff};
         `TEC_OFS_IRQ_MASK:
            rd_mux = {15'h0000, mask_ff};
         `TEC_OFS_RUN_STAT:
            rd_mux = {14'h0000, pend_ff, run_ff};
         default:
            rd_mux = 16'h0000;
      endcase
   end

   always @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
         RDATA <= 16'h0000;
      else if (RD)
         RDATA <= rd_mux;
      else
         RDATA <= 16'h0000;
   end

endmodule // tec_timer

`default_nettype wire

// *** sim/tec_chk_asserts.sv ***
// Port checker for the timer, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module tec_chk
(
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // Register port
   input wire logic [7:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [15:0] RDATA,
   // Events
   input wire logic PWR_STOP_ENTER,
   input wire logic MATCH_PULSE,
   input wire logic IRQ
);
   logic msk_ff;
   default clocking @(posedge SYS_CLK);
   endclocking
   default disable iff (RST);
   // Shadow of the interrupt mask
   always @(posedge SYS_CLK or posedge RST)
      if (RST)
         msk_ff <= 1'b0;
      else if (WR && ADDR == 8'h18)
         msk_ff <= WDATA[0];
   chk_pulse_one: assert property (MATCH_PULSE |=> !MATCH_PULSE)
      else $error("match pulse too long");
   chk_match_irq: assert property (
      MATCH_PULSE && msk_ff |-> ##[1:2] IRQ) else $error("no irq");
   chk_irq_cause: assert property ($rose(IRQ) |->
      $past(MATCH_PULSE || WR) || $past(MATCH_PULSE || WR, 2))
      else $error("irq without cause");
   chk_irq_clear: assert property ($fell(IRQ) |-> $past(WR) || $past(WR, 2))
      else $error("irq dropped by itself");
   chk_irq_mask: assert property (IRQ |-> msk_ff)
      else $error("masked irq seen");
   chk_rd_idle: assert property (!$past(RD) |-> RDATA == 16'h0)
      else $error("read data outside its cycle");
   chk_rd_unmap: assert property ($past(RD) && $past(ADDR) > 8'h1C |->
      RDATA == 16'h0) else $error("unmapped read not zero");
   chk_stop_halt: assert property (
      PWR_STOP_ENTER |=> ##1 !MATCH_PULSE [*8]) else $error("runs after stop");
   cover property (MATCH_PULSE);
   cover property ($rose(IRQ));
   cover property (PWR_STOP_ENTER);
endmodule // tec_chk
bind tec_timer tec_chk u_chk (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
   .PWR_STOP_ENTER(PWR_STOP_ENTER), .MATCH_PULSE(MATCH_PULSE), .IRQ(IRQ));
`default_nettype wire

// *** sim/tec_pulse_src.sv ***
// Pulse source that drives the counter input pin
`timescale 1ns/1ps
`default_nettype none
module tec_pulse_src
(
   // Clock
   input wire logic clk,
   // Request
   input wire logic go,
   input wire logic [15:0] width,
   // Pin
   output wire logic pin
);
   logic [15:0] cnt_ff = 16'h0;
   logic pin_ff = 1'b0;
   assign pin = pin_ff;
   // Toggle on request; a nonzero width toggles back after that many cycles
   always @(posedge clk)
      if (go)
      begin
         pin_ff <= !pin_ff;
         cnt_ff <= width;
      end
      else if (cnt_ff == 16'h1)
      begin
         pin_ff <= !pin_ff;
         cnt_ff <= 16'h0;
      end
      else if (cnt_ff != 16'h0)
         cnt_ff <= cnt_ff - 16'h1;
endmodule // tec_pulse_src
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the timer
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, low = 1'b0;
   logic stp = 1'b0, tk = 1'b0, go = 1'b0, rdp = 1'b0;
   logic pin, mp, irq, f;
   logic [7:0] addr = 8'h0;
   logic [15:0] wd = 16'h0, wid = 16'h0, rdata, c;
   logic [31:0] rs = 32'h28;
   logic [15:0] q[$];
   logic [7:0] cw[3] = '{8'h29, 8'h25, 8'h21};
   logic [15:0] dv[3] = '{16'h8, 16'h80, 16'h800};
   int errors = 0, cmp_count = 0, n;
   always #2.5 clk = !clk;
   tec_timer dut (.SYS_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wd),
      .WR(wr), .RD(rd), .RDATA(rdata), .PWR_LOW_SPEED(low),
      .PWR_STOP_ENTER(stp), .SLOW_OSC_TICK(tk), .CNT_IN_PIN(pin),
      .MATCH_PULSE(mp), .IRQ(irq));
   tec_pulse_src src (.clk(clk), .go(go), .width(wid), .pin(pin));
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Random slow oscillator ticks, and the read-data watcher
   always @(posedge clk)
   begin
      rs <= xs(rs);
      tk <= rs[0];
      if (rdp)
         chk(rdata, q.pop_front());
      rdp <= rd;
   end
   task automatic wreg(input logic [7:0] a, input logic [15:0] d);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rreg(input logic [7:0] a, input logic [15:0] e);
      q.push_back(e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic setc(input logic [15:0] v);
      wreg(8'h04, {8'h0, v[7:0]});
      wreg(8'h08, {8'h0, v[15:8]});
   endtask
   task automatic pulse(input logic [15:0] w);
      wid <= w;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
   endtask
   task automatic hit(input int lim, input logic e);
      n = 0;
      f = 1'b0;
      while (!f && n < lim)
      begin
         @(posedge clk);
         n++;
         f = mp === 1'b1;
      end
      chk({15'h0, f}, {15'h0, e});
      if (e && !f)
         final_report();
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      wreg(8'h20, 16'hFFFF);
      rreg(8'h00, 16'h0);
      rreg(8'h20, 16'h0);
      wreg(8'h00, 16'h0C);
      wreg(8'h04, 16'h12);
      rreg(8'h04, 16'hFF);
      wreg(8'h08, 16'h34);
      rreg(8'h1C, 16'h2);
      rreg(8'h08, 16'hFF);
      wreg(8'h00, 16'h08);
      repeat (20) @(posedge clk);
      rreg(8'h04, 16'h12);
      rreg(8'h1C, 16'h0);
      wreg(8'h18, 16'h1);
      for (int i = 0; i < 3; i++)
      begin
         c = {14'h0, rs[1:0]} + 16'h2;
         setc(c);
         repeat (130) @(posedge clk);
         wreg(8'h00, {8'h0, cw[i]});
         hit(20000, 1'b1);
         rreg(8'h0C, c);
         rreg(8'h10, 16'h0);
         hit(20000, 1'b1);
         chk(16'(n + 4), (c + 16'h1) * dv[i]);
         wreg(8'h00, {8'h0, cw[i] & 8'h0C});
         rreg(8'h10, 16'h0);
      end
      rreg(8'h14, 16'h1);
      chk({15'h0, irq}, 16'h1);
      wreg(8'h18, 16'h0);
      chk({15'h0, irq}, 16'h0);
      wreg(8'h14, 16'h1);
      rreg(8'h14, 16'h0);
      wreg(8'h18, 16'h1);
      wreg(8'h00, 16'h29);
      repeat (30) @(posedge clk);
      stp <= 1'b1;
      @(posedge clk);
      stp <= 1'b0;
      repeat (20) @(posedge clk);
      rreg(8'h00, 16'h28);
      rreg(8'h10, 16'h0);
      setc(16'h4);
      wreg(8'h00, 16'h4A);
      hit(60, 1'b0);
      rreg(8'h10, 16'h0);
      pulse(16'h0);
      hit(100, 1'b1);
      hit(100, 1'b0);
      rreg(8'h10, 16'h0);
      pulse(16'h0);
      hit(30, 1'b0);
      pulse(16'h0);
      hit(100, 1'b1);
      setc(16'h14);
      pulse(16'h0);
      repeat (20) @(posedge clk);
      pulse(16'h0);
      repeat (28) @(posedge clk);
      pulse(16'hC);
      hit(165, 1'b1);
      wreg(8'h00, 16'h28);
      wreg(8'h14, 16'h1);
      wreg(8'h00, 16'h5A);
      pulse(16'h0);
      repeat (20) @(posedge clk);
      pulse(16'h1E);
      hit(200, 1'b0);
      rreg(8'h10, 16'h0);
      rreg(8'h14, 16'h0);
      wreg(8'h00, 16'h28);
      wreg(8'h00, 16'h4A);
      pulse(16'h4);
      hit(200, 1'b0);
      pulse(16'hC);
      hit(200, 1'b1);
      wreg(8'h00, 16'h0);
      low <= 1'b1;
      setc(16'h1);
      repeat (100) @(posedge clk);
      wreg(8'h00, 16'h42);
      pulse(16'h2);
      hit(300, 1'b1);
      // Prescaler tap: code 00 counts every eighth slow oscillator tick at full speed
      low <= 1'b0;
      wreg(8'h00, 16'h81);
      hit(300, 1'b1);
      // Falling-edge trigger; the rising edge must not start the count
      wreg(8'h00, 16'h00);
      wreg(8'h00, 16'h4B);
      pulse(16'h0);
      hit(40, 1'b0);
      pulse(16'h0);
      hit(60, 1'b1);
      final_report();
   end
endmodule // tb
`default_nettype wire
